// File: design/sbm_host.sv
// Functional notes
// - start address sent as thirteen serial bits
// - dummy top bit driven to a level
// - write select high reads, low writes
// - write select falling mid-cycle gives modify
// - test inputs held at inactive levels
// - wait one millisecond after power-up
// - ten dummy reads before real accesses
`timescale 1ns/1ps
`default_nettype none
module sbm_host
	import sbm_pkg::*;
#(
	parameter int PWRUP_CYCLES = CY_PWRUP,
	parameter int DATA_W       = 1,
	parameter int DEPTH        = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// command port
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire sbm_op_t               cmd_op,
	input  wire logic [BLOCK_BITS-1:0] cmd_block,
	input  wire logic                  cmd_wdata,
	// read data stream
	output logic                       rd_valid,
	input  wire logic                  rd_ready,
	output logic      [DATA_W-1:0]     rd_data,
	// status
	output logic                       init_done,
	output logic                       busy,
	// device pins
	output logic                       serial_addr_pin,
	output logic                       addr_shift_strobe_n,
	output logic                       addr_load_strobe_n,
	output logic                       access_clock_n,
	output logic                       write_sel_n,
	output logic                       dev_sel_n,
	output logic                       data_to_dev,
	input  wire logic                  data_from_dev,
	output logic                       test_hi,
	output logic                       test_lo_n
);

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [3:0] {
		ST_PWRUP,
		ST_IDLE,
		ST_SHIFT_LO,
		ST_SHIFT_HI,
		ST_LOAD_LO,
		ST_LOAD_HI,
		ST_WSETUP,
		ST_CK_LO,
		ST_RMW_WE,
		ST_CK_HI
	} sbm_state_t;

	sbm_state_t            state_reg;
	logic [TIMER_W-1:0]    timer_reg;
	logic [3:0]            bit_reg;
	logic [3:0]            dummy_cnt_reg;
	logic [BLOCK_BITS-1:0] block_reg;
	sbm_op_t               op_reg;
	logic                  init_done_reg;
	logic                  push;
	logic                  fifo_in_ready;
	logic                  accept;
	logic                  tdone;

	function automatic logic [TIMER_W-1:0] tload(input int cycles);
		tload = TIMER_W'(cycles - 1);
	endfunction : tload

	assign tdone     = timer_reg == '0;
	assign accept    = cmd_valid && cmd_ready;
	assign init_done = init_done_reg;
	assign busy      = state_reg != ST_IDLE;
	// reads only start when the stream has room for the bit
	assign cmd_ready = (state_reg == ST_IDLE) && init_done_reg &&
	                   (cmd_op == SBM_OP_LOAD || cmd_op == SBM_OP_WRITE || fifo_in_ready);
	assign test_hi   = 1'b0;
	assign test_lo_n = 1'b1;
	// select one cycle ahead of the first dummy clock fall
	assign dev_sel_n = !init_done_reg && state_reg == ST_PWRUP &&
	                   timer_reg != tload(PWRUP_CYCLES);

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg     <= ST_PWRUP;
			timer_reg     <= '0;
			bit_reg       <= '0;
			dummy_cnt_reg <= '0;
			init_done_reg <= 1'b0;
		end else begin
			if (!tdone) begin
				timer_reg <= timer_reg - TIMER_W'(1);
			end
			case (state_reg)
				ST_PWRUP: begin
					if (timer_reg == tload(PWRUP_CYCLES)) begin
						state_reg <= ST_CK_LO;
						timer_reg <= tload(CY_RW);
					end else begin
						timer_reg <= timer_reg + TIMER_W'(1);
					end
				end
				ST_IDLE: begin
					if (accept) begin
						if (cmd_op == SBM_OP_LOAD) begin
							state_reg <= ST_SHIFT_LO;
							timer_reg <= tload(CY_SHIFT);
							bit_reg   <= '0;
						end else if (cmd_op == SBM_OP_WRITE) begin
							state_reg <= ST_WSETUP;
						end else begin
							state_reg <= ST_CK_LO;
							timer_reg <= (cmd_op == SBM_OP_RMW) ? tload(CY_ACC) : tload(CY_RW);
						end
					end
				end
				ST_SHIFT_LO: begin
					if (tdone) begin
						state_reg <= ST_SHIFT_HI;
						timer_reg <= tload(CY_SAP);
					end
				end
				ST_SHIFT_HI: begin
					if (tdone) begin
						if (bit_reg == 4'(ADDR_BITS - 1)) begin
							state_reg <= ST_LOAD_LO;
							timer_reg <= tload(CY_LOAD);
						end else begin
							state_reg <= ST_SHIFT_LO;
							timer_reg <= tload(CY_SHIFT);
							bit_reg   <= bit_reg + 4'(1);
						end
					end
				end
				ST_LOAD_LO: begin
					if (tdone) begin
						state_reg <= ST_LOAD_HI;
						timer_reg <= tload(CY_TRS);
					end
				end
				ST_WSETUP: begin
					state_reg <= ST_CK_LO;
					timer_reg <= tload(CY_RW);
				end
				ST_CK_LO: begin
					if (tdone) begin
						if (init_done_reg && op_reg == SBM_OP_RMW) begin
							state_reg <= ST_RMW_WE;
							timer_reg <= tload(CY_WP);
						end else begin
							state_reg <= ST_CK_HI;
							timer_reg <= tload(CY_RWP);
						end
					end
				end
				ST_RMW_WE: begin
					if (tdone) begin
						state_reg <= ST_CK_HI;
						timer_reg <= tload(CY_RWP);
					end
				end
				ST_LOAD_HI, ST_CK_HI: begin
					if (tdone) begin
						if (!init_done_reg) begin
							if (dummy_cnt_reg == 4'(DUMMY_READS - 1)) begin
								init_done_reg <= 1'b1;
								state_reg     <= ST_IDLE;
							end else begin
								dummy_cnt_reg <= dummy_cnt_reg + 4'(1);
								state_reg     <= ST_CK_LO;
								timer_reg     <= tload(CY_RW);
							end
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// command capture
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			op_reg      <= SBM_OP_READ;
			block_reg   <= '0;
			data_to_dev <= 1'b0;
		end else if (accept) begin
			op_reg      <= cmd_op;
			block_reg   <= cmd_block;
			data_to_dev <= cmd_wdata;
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			serial_addr_pin     <= 1'b0;
			addr_shift_strobe_n <= 1'b1;
			addr_load_strobe_n  <= 1'b1;
			access_clock_n      <= 1'b1;
			write_sel_n         <= 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (accept && cmd_op == SBM_OP_LOAD) begin
						serial_addr_pin     <= cmd_block[0];
						addr_shift_strobe_n <= 1'b0;
					end else if (accept && cmd_op == SBM_OP_WRITE) begin
						write_sel_n <= 1'b0;
					end else if (accept) begin
						access_clock_n <= 1'b0;
					end
				end
				ST_PWRUP: begin
					if (timer_reg == tload(PWRUP_CYCLES)) begin
						access_clock_n <= 1'b0;
					end
				end
				ST_SHIFT_LO: begin
					if (tdone) begin
						addr_shift_strobe_n <= 1'b1;
					end
				end
				ST_SHIFT_HI: begin
					if (tdone && bit_reg == 4'(ADDR_BITS - 1)) begin
						addr_load_strobe_n <= 1'b0;
					end else if (tdone) begin
						// top bit is the dummy, driven low
						serial_addr_pin     <= (bit_reg == 4'(BLOCK_BITS - 1)) ? 1'b0
						                       : block_reg[bit_reg + 4'(1)];
						addr_shift_strobe_n <= 1'b0;
					end
				end
				ST_LOAD_LO: begin
					if (tdone) begin
						addr_load_strobe_n <= 1'b1;
					end
				end
				ST_WSETUP: begin
					access_clock_n <= 1'b0;
				end
				ST_CK_LO: begin
					if (tdone && init_done_reg && op_reg == SBM_OP_RMW) begin
						write_sel_n <= 1'b0;
					end else if (tdone) begin
						access_clock_n <= 1'b1;
					end
				end
				ST_RMW_WE: begin
					if (tdone) begin
						access_clock_n <= 1'b1;
					end
				end
				ST_CK_HI: begin
					if (tdone) begin
						write_sel_n <= 1'b1;
					end
				end
				ST_LOAD_HI: begin
					if (tdone && !init_done_reg) begin
						access_clock_n <= 1'b0;
					end
				end
				default: begin
				end
			endcase
			if (state_reg == ST_CK_HI && tdone && !init_done_reg &&
			    dummy_cnt_reg != 4'(DUMMY_READS - 1)) begin
				access_clock_n <= 1'b0;
			end
		end
	end

	// ****************************************
	// read data capture
	// ****************************************
	// sample at end of read low phase, before the clock rises
	assign push = state_reg == ST_CK_LO && tdone && init_done_reg &&
	              (op_reg == SBM_OP_READ || op_reg == SBM_OP_RMW);

	sbm_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (DATA_W'(data_from_dev)),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

endmodule : sbm_host
`default_nettype wire

// File: design/sbm_pkg.sv
package sbm_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_MHZ      = 40;
	localparam int T_PWRUP_MS   = 1;
	localparam int T_RW_NS      = 1500;
	localparam int T_RWP_NS     = 1000;
	localparam int T_ACC_NS     = 1500;
	localparam int T_SHIFT_NS   = 50;
	localparam int T_SAP_NS     = 50;
	localparam int T_AH_NS      = 50;
	localparam int T_LOAD_NS    = 50;
	localparam int T_TRS_NS     = 50;
	localparam int T_WP_NS      = 50;
	localparam int T_RWL_NS     = 50;

	// least time in ns rounded up to whole cycles, never below one
	function automatic int ns_min(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		ns_min = (c < 1) ? 1 : c;
	endfunction : ns_min

	localparam int CY_PWRUP = T_PWRUP_MS * 1000 * CLK_MHZ;
	localparam int CY_RW    = ns_min(T_RW_NS);
	localparam int CY_RWP   = ns_min(T_RWP_NS);
	localparam int CY_ACC   = ns_min(T_ACC_NS);
	localparam int CY_SHIFT = ns_min(T_SHIFT_NS);
	localparam int CY_SAP   = ns_min(T_SAP_NS + T_AH_NS);
	localparam int CY_LOAD  = ns_min(T_LOAD_NS);
	localparam int CY_TRS   = ns_min(T_TRS_NS);
	localparam int CY_WP    = ns_min(T_WP_NS + T_RWL_NS);

	// ****************************************
	// addressing and sizes
	// ****************************************
	localparam int ADDR_BITS   = 13;
	localparam int BLOCK_BITS  = 12;
	localparam int DUMMY_READS = 10;
	localparam int FIFO_DEPTH  = 16;
	localparam int TIMER_W     = 16;

	typedef enum logic [1:0] {
		SBM_OP_LOAD,
		SBM_OP_READ,
		SBM_OP_WRITE,
		SBM_OP_RMW
	} sbm_op_t;

endpackage : sbm_pkg

// File: design/sbm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sbm_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW:0]      wr_ptr_reg;
	logic [PW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data  = mem_reg[rd_ptr_reg[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + (PW+1)'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + (PW+1)'(1);
			end
		end
	end

endmodule : sbm_fifo
`default_nettype wire

// File: tb/sbm_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sbm_host_sva
	import sbm_pkg::*;
#(
	parameter int PWRUP_CYCLES = CY_PWRUP
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// command and status
	input wire logic cmd_ready,
	input wire logic init_done,
	// device pins
	input wire logic serial_addr_pin,
	input wire logic addr_shift_strobe_n,
	input wire logic addr_load_strobe_n,
	input wire logic access_clock_n,
	input wire logic write_sel_n,
	input wire logic dev_sel_n,
	input wire logic test_hi,
	input wire logic test_lo_n
);
	// ****
	// helper counters
	// ****
	int         pw_reg;
	logic [3:0] falls_reg;
	logic [3:0] shifts_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk_sys) begin
		if (!rstn) pw_reg <= 0;
		else if (pw_reg < PWRUP_CYCLES) pw_reg <= pw_reg + 1;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) falls_reg <= 4'h0;
		else if ($fell(access_clock_n) && falls_reg != 4'hF) falls_reg <= falls_reg + 4'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) shifts_reg <= 4'h0;
		else if ($fell(addr_load_strobe_n)) shifts_reg <= 4'h0;
		else if ($fell(addr_shift_strobe_n)) shifts_reg <= shifts_reg + 4'h1;
	end
	// ****
	// properties
	// ****
	sequence s_clk_low;
		!access_clock_n [*8];
	endsequence
	chk_test_levels: assert property (!test_hi && test_lo_n)
		else $error("test pins left active");
	chk_pwrup_quiet: assert property (pw_reg < PWRUP_CYCLES |-> access_clock_n && !init_done)
		else $error("access during power-up wait");
	chk_dummy_first: assert property ($rose(init_done) |-> falls_reg >= 4'hA)
		else $error("too few dummy reads");
	chk_ready_init: assert property (cmd_ready |-> init_done && access_clock_n && write_sel_n
		&& addr_shift_strobe_n && addr_load_strobe_n)
		else $error("command taken before init or with pins active");
	chk_addr_count: assert property ($fell(addr_load_strobe_n) |-> shifts_reg == 4'hD)
		else $error("load not after thirteen shifts");
	chk_dummy_level: assert property ($fell(addr_shift_strobe_n) && shifts_reg == 4'hC
		|-> !serial_addr_pin)
		else $error("top address bit not low");
	chk_addr_steady: assert property (!addr_shift_strobe_n && !$past(addr_shift_strobe_n)
		|-> $stable(serial_addr_pin))
		else $error("address pin moved in strobe");
	chk_clk_pulse: assert property ($fell(access_clock_n) |-> s_clk_low)
		else $error("access pulse too short");
	chk_wsel_rise: assert property ($rose(write_sel_n) |-> access_clock_n)
		else $error("write select left mid access");
	chk_sel_active: assert property (init_done || !access_clock_n |-> !dev_sel_n)
		else $error("device not selected");
endmodule : sbm_host_sva
`default_nettype wire

// File: tb/sbm_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbm_dev_model (
	// address pins
	input  wire logic serial_addr_pin,
	input  wire logic addr_shift_strobe_n,
	input  wire logic addr_load_strobe_n,
	// access pins
	input  wire logic access_clock_n,
	input  wire logic write_sel_n,
	input  wire logic dev_sel_n,
	input  wire logic data_to_dev,
	output logic      data_from_dev
);
	// 22-bit counter spans every word and wraps; refresh is internal
	logic [12:0] sar = '0;
	logic [21:0] ctr = '0;
	logic        mem [int];
	logic        q   = 1'b0;
	logic        drv = 1'b0;
	// latch on the trailing edge, clear of the pin change at the leading edge
	always @(posedge addr_shift_strobe_n)
		if (!dev_sel_n) sar <= {serial_addr_pin, sar[12:1]};
	always @(negedge addr_load_strobe_n)
		if (!dev_sel_n) ctr <= {sar[11:0], 10'h000};
	always @(negedge access_clock_n)
		if (!dev_sel_n) begin
			if (write_sel_n) begin
				q <= mem.exists(ctr) ? mem[ctr] : 1'b0;
				drv <= #1400 1'b1;
			end else
				mem[ctr] = data_to_dev;
		end
	always @(negedge write_sel_n)
		if (!dev_sel_n && !access_clock_n) mem[ctr] = data_to_dev;
	always @(posedge access_clock_n)
		if (!dev_sel_n) begin
			ctr <= ctr + 22'h000001;
			drv <= 1'b0;
		end
	// released output shows the inverse of the last bit
	assign data_from_dev = (drv && !access_clock_n && !dev_sel_n) ? q : ~q;
endmodule : sbm_dev_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sbm_pkg::*;
	logic                  clk_sys   = 1'b0;
	logic                  rstn      = 1'b0;
	logic                  cmd_valid = 1'b0;
	sbm_op_t               cmd_op    = SBM_OP_LOAD;
	logic [BLOCK_BITS-1:0] cmd_block = '0;
	logic                  cmd_wdata = 1'b0;
	logic                  rd_ready  = 1'b0;
	logic [0:0]            rd_data;
	logic cmd_ready, rd_valid, init_done, busy, serial_addr_pin, addr_shift_strobe_n;
	logic addr_load_strobe_n, access_clock_n, write_sel_n, dev_sel_n, data_to_dev;
	logic data_from_dev, test_hi, test_lo_n;
	logic [31:0] rs = 32'h0000003B;
	logic sh [int];
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	always #12.5 clk_sys = ~clk_sys;
	sbm_host #(.PWRUP_CYCLES(20)) u_dut (.clk_sys, .rstn, .cmd_valid, .cmd_ready, .cmd_op,
		.cmd_block, .cmd_wdata, .rd_valid, .rd_ready, .rd_data, .init_done, .busy,
		.serial_addr_pin, .addr_shift_strobe_n, .addr_load_strobe_n, .access_clock_n,
		.write_sel_n, .dev_sel_n, .data_to_dev, .data_from_dev, .test_hi, .test_lo_n);
	sbm_dev_model u_dev (.serial_addr_pin, .addr_shift_strobe_n, .addr_load_strobe_n,
		.access_clock_n, .write_sel_n, .dev_sel_n, .data_to_dev, .data_from_dev);
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : xs
	function automatic logic rd_of(input int a);
		return sh.exists(a) ? sh[a] : 1'b0;
	endfunction : rd_of
	task automatic tally_and_finish();
		if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	task automatic cmd(input sbm_op_t op, input logic [BLOCK_BITS-1:0] blk, input logic wd);
		@(negedge clk_sys);
		cmd_op = op;
		cmd_block = blk;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (busy !== 1'b0) @(negedge clk_sys);
	endtask : cmd
	task automatic pop(input logic e, input logic [1:0] stall);
		repeat (stall + 1) @(negedge clk_sys);
		rd_ready = 1'b1;
		while (rd_valid !== 1'b1) @(negedge clk_sys);
		chk(rd_data, e);
		@(negedge clk_sys);
		rd_ready = 1'b0;
	endtask : pop
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		logic [31:0] v;
		logic [11:0] blk;
		int a;
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		chk(cmd_ready, 1'b0);
		chk({test_hi, test_lo_n}, 2'b01);
		chk({busy, init_done}, 2'b10);
		for (int r = 0; r < 4; r++) begin
			v = xs();
			blk = (r == 0) ? 12'hFFF : (r == 1) ? 12'h000 : v[11:0];
			cmd(SBM_OP_LOAD, blk, 1'b0);
			chk(u_dev.ctr, {blk, 10'h000});
			chk(u_dev.sar[12], 1'b0);
			for (int i = 0; i < 6; i++) begin
				v = xs();
				a = {blk, 10'h000} + i;
				cmd(v[1] ? SBM_OP_RMW : SBM_OP_WRITE, blk, v[0]);
				if (v[1]) pop(rd_of(a), v[3:2]);
				sh[a] = v[0];
			end
			chk(u_dev.ctr, a + 1);
			cmd(SBM_OP_LOAD, blk, 1'b0);
			for (int i = 0; i < 16; i++) cmd(SBM_OP_READ, blk, 1'b0);
			@(negedge clk_sys);
			chk(cmd_ready, 1'b0);
			cmd_op = SBM_OP_WRITE;
			@(negedge clk_sys);
			chk(cmd_ready, 1'b1);
			for (int i = 0; i < 16; i++) begin
				v = xs();
				pop(rd_of({blk, 10'h000} + i), v[1:0]);
			end
			chk(rd_valid, 1'b0);
		end
		tally_and_finish();
	end
endmodule : tb_top
bind sbm_host sbm_host_sva #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_sva (.clk_sys, .rstn,
	.cmd_ready, .init_done, .serial_addr_pin, .addr_shift_strobe_n, .addr_load_strobe_n,
	.access_clock_n, .write_sel_n, .dev_sel_n, .test_hi, .test_lo_n);
`default_nettype wire
